/* core/eda_map.vh */
// Behaviour
// - Hold 128 bytes of nonvolatile data, each byte readable and writable.
// - Only even addresses hold data; software steps addresses by two.
// - External write to EE00h..EEFEh starts a write of the accumulator byte.
// - Byte write stalls CPU about 2 ms at 3 V, 1 ms at 5 V; the code counts a fixed 1 ms at any supply.
// - Peripherals keep running during the stall; only instruction execution waits.
// - One write time-out is shared by data writes and flash writes.
// - External read of EE00h..EEFEh returns the stored byte in about 300 ns.
// - Key 47h sets flash enable, E2h sets data enable, else clears both.
// - Key register bit 5 shows data write enable; writes accepted only then.
// - Select 00 off; 01,10,11 wait 1.5,5.8,11.7 ms, then flag and abandon.
`ifndef EDA_MAP_VH
`define EDA_MAP_VH
`define EDA_SFR_KEY 8'hC9
`define EDA_SFR_MISC 8'hF7
`define EDA_KEY_FLASH 8'h47
`define EDA_KEY_DATA 8'hE2
`define EDA_BIT_FLASH_WE 7
`define EDA_BIT_TIMEOUT 6
`define EDA_BIT_DATA_WE 5
`define EDA_TSEL_LSB 1
`define EDA_MISC_RESET 8'h06
`define EDA_WIN_HI 8'hEE
`define EDA_CLK_KHZ 40000
// Times in microseconds / nanoseconds
`define EDA_WRITE_US 1000
`define EDA_READ_NS 300
`define EDA_TO1_US 1500
`define EDA_TO2_US 5800
`define EDA_TO3_US 11700
`define EDA_READ_CYC ((`EDA_READ_NS * `EDA_CLK_KHZ + 999999) / 1000000)
`endif

/* core/eda_store.v */
`timescale 1ns/1ps
// Byte array of the nonvolatile data space
module eda_store #(
   parameter DEPTH = 128,
   parameter AW = 7
) (
   input wire clk, // System clock
   input wire we, // Commit write
   input wire [AW-1:0] addr, // Byte index
   input wire [7:0] wdata, // Write byte
   output reg [7:0] rdata // Registered read byte
);
   reg [7:0] mem [0:DEPTH-1];

   // Synchronous array port
   always @(posedge clk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end
endmodule // eda_store

/* core/eda_ctrl.v */
`timescale 1ns/1ps
`include "eda_map.vh"
// Nonvolatile data access controller on the CPU external data bus
// Write time is a fixed count; a cell done pulse may end it sooner
module eda_ctrl #(
   parameter WRITE_CYC = `EDA_WRITE_US * (`EDA_CLK_KHZ / 1000),
   parameter TO1_CYC = `EDA_TO1_US * (`EDA_CLK_KHZ / 1000),
   parameter TO2_CYC = `EDA_TO2_US * (`EDA_CLK_KHZ / 1000),
   parameter TO3_CYC = `EDA_TO3_US * (`EDA_CLK_KHZ / 1000)
) (
   input wire clk, // 40 MHz system clock
   input wire rst, // Synchronous reset, high
   input wire [15:0] xaddr, // External data address
   input wire [7:0] xwdata, // Accumulator byte
   input wire xwr, // External write strobe, one cycle
   input wire xrd, // External read strobe, one cycle
   input wire [7:0] sfr_addr, // SFR address
   input wire [7:0] sfr_wdata, // SFR write data
   input wire sfr_wr, // SFR write strobe
   input wire flash_busy, // Flash write in progress
   input wire nv_busy_done, // Cell reports write complete
   output reg [7:0] xrdata_r, // Read byte
   output reg xrdata_valid_r, // Read data valid pulse
   output reg cpu_wait_r, // Stall instruction execution
   output reg [7:0] sfr_rdata_r, // SFR read data
   output reg flash_abort_r, // Abandon flash write pulse
   output reg flash_write_enable_r, // Flash write enable flag
   output reg nv_data_write_enable_r, // Data write enable flag
   output reg write_timeout_flag_r // Time-out flag
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WRITE = 2'd1;
   localparam ST_READ = 2'd2;
   // Read time rounded up to whole clocks
   localparam RD_CYC_INT = `EDA_READ_CYC;
   localparam [23:0] RD_CYC = RD_CYC_INT[23:0];

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [7:0] misc_control_r;
   reg [23:0] cnt_r;
   reg [23:0] to_cnt_r;
   reg [6:0] addr_r;
   reg [7:0] data_r;
   reg commit_r;
   wire [7:0] rdata;
   wire [1:0] write_timeout_select;
   wire in_win;
   wire wr_ok;
   wire wr_busy;
   wire to_hit;
   wire [23:0] to_lim;
   wire rd_ok;
   wire key_wr;
   wire misc_wr;
   reg [7:0] key_status;

   // Time-out limit per select code
   // Code 00 falls to the long limit here but is gated off in to_hit
   function [23:0] to_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'b01: to_limit = TO1_CYC[23:0];
            2'b10: to_limit = TO2_CYC[23:0];
            default: to_limit = TO3_CYC[23:0];
         endcase
      end
   endfunction

   assign write_timeout_select = misc_control_r[`EDA_TSEL_LSB+1:`EDA_TSEL_LSB];
   assign in_win = (xaddr[15:8] == `EDA_WIN_HI);
   // Odd reads alias the even byte below; they hold no data of their own
   assign rd_ok = xrd && in_win;
   assign key_wr = sfr_wr && (sfr_addr == `EDA_SFR_KEY);
   assign misc_wr = sfr_wr && (sfr_addr == `EDA_SFR_MISC);
   // Odd address or disabled write is dropped
   assign wr_ok = xwr && in_win && !xaddr[0] && nv_data_write_enable_r;
   assign wr_busy = (state_r == ST_WRITE) || flash_busy;
   // Time-out counts only while some write is in flight
   assign to_lim = to_limit(write_timeout_select);
   assign to_hit = wr_busy && (write_timeout_select != 2'b00) && (to_cnt_r >= to_lim);

   // Array sees only the latched index, so the CPU may move its pointer
   // once a request is taken; the read timer hides the array's own cycle
   eda_store #(
      .DEPTH(128),
      .AW(7)
   ) u_store (
      .clk(clk),
      .we(commit_r),
      .addr(addr_r),
      .wdata(data_r),
      .rdata(rdata)
   );

   // Next state
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (wr_ok)
               state_nxt = ST_WRITE;
            else if (rd_ok)
               state_nxt = ST_READ;
         end
         ST_WRITE:
         begin
            // Time-out, cell completion or our own write time, whichever first
            if (to_hit || nv_busy_done || cnt_r >= WRITE_CYC[23:0] - 24'h000001)
               state_nxt = ST_IDLE;
         end
         ST_READ:
         begin
            // Pads the read out to its rated time
            if (cnt_r >= RD_CYC - 24'h000001)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Sequencer; only the CPU waits, peripherals see no change
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 24'h000000;
         addr_r <= 7'h00;
         data_r <= 8'h00;
         commit_r <= 1'b0;
         cpu_wait_r <= 1'b0;
         xrdata_r <= 8'h00;
         xrdata_valid_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         commit_r <= 1'b0;
         xrdata_valid_r <= 1'b0;
         cnt_r <= (state_nxt == state_r) ? cnt_r + 24'h000001 : 24'h000000;
         // Latch the request; byte index drops the pointer's low bit
         if (state_r == ST_IDLE && (wr_ok || rd_ok))
         begin
            addr_r <= xaddr[7:1];
            data_r <= xwdata;
         end
         // Commit at successful end; an abandoned write leaves data untouched
         if (state_r == ST_WRITE && state_nxt == ST_IDLE && !to_hit)
            commit_r <= 1'b1;
         // Stall follows the state, so the CPU resumes right after the write
         cpu_wait_r <= (state_nxt == ST_WRITE);
         if (state_r == ST_READ && state_nxt == ST_IDLE)
         begin
            xrdata_r <= rdata;
            xrdata_valid_r <= 1'b1;
         end
      end
   end

   // Shared time-out counter for both write paths
   // Trade-off: one counter, so both paths obey the same select code
   always @(posedge clk)
   begin
      if (rst || !wr_busy || to_hit)
         to_cnt_r <= 24'h000000;
      else
         to_cnt_r <= to_cnt_r + 24'h000001;
   end

   // Key and control registers
   always @(posedge clk)
   begin
      if (rst)
      begin
         flash_write_enable_r <= 1'b0;
         nv_data_write_enable_r <= 1'b0;
         write_timeout_flag_r <= 1'b0;
         misc_control_r <= `EDA_MISC_RESET;
         flash_abort_r <= 1'b0;
      end
      else
      begin
         flash_abort_r <= to_hit && flash_busy;
         if (misc_wr)
            misc_control_r <= sfr_wdata;
         // Any value but the two keys closes both paths
         if (key_wr)
         begin
            flash_write_enable_r <= (sfr_wdata == `EDA_KEY_FLASH);
            nv_data_write_enable_r <= (sfr_wdata == `EDA_KEY_DATA);
         end
         // Set wins over a same-cycle clear; cleared once both enables drop
         if (to_hit)
            write_timeout_flag_r <= 1'b1;
         else if (!flash_write_enable_r && !nv_data_write_enable_r)
            write_timeout_flag_r <= 1'b0;
      end
   end

   // Key register status image; unused low bits read as zero
   always @*
   begin
      key_status = 8'h00;
      key_status[`EDA_BIT_FLASH_WE] = flash_write_enable_r;
      key_status[`EDA_BIT_TIMEOUT] = write_timeout_flag_r;
      key_status[`EDA_BIT_DATA_WE] = nv_data_write_enable_r;
   end

   // SFR read-back, one cycle behind the address
   always @(posedge clk)
   begin
      if (rst)
         sfr_rdata_r <= 8'h00;
      else if (sfr_addr == `EDA_SFR_KEY)
         sfr_rdata_r <= key_status;
      else if (sfr_addr == `EDA_SFR_MISC)
         sfr_rdata_r <= misc_control_r;
      else
         sfr_rdata_r <= 8'h00;
   end
endmodule // eda_ctrl

/* verification/eda_ctrl_sva.sv */
`timescale 1ns/1ps
// Port checks on the data access controller
module eda_ctrl_sva (
   input wire clk, // Clock
   input wire rst, // Reset
   input wire [15:0] xaddr, // Address
   input wire xwr, // Write
   input wire xrd, // Read
   input wire [7:0] sfr_addr, // SFR
   input wire [7:0] sfr_wdata, // SFR data
   input wire sfr_wr, // SFR write
   input wire flash_busy, // Flash busy
   input wire flash_abort_r, // Flash abort
   input wire xrdata_valid_r, // Valid
   input wire cpu_wait_r, // Stall
   input wire flash_write_enable_r, // Flash en
   input wire nv_data_write_enable_r, // Data en
   input wire write_timeout_flag_r // Time-out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Key and window decodes
   wire key = sfr_wr && sfr_addr == 8'hC9;
   wire win = xaddr[15:8] == 8'hEE;
   property p_kdat; key && sfr_wdata == 8'hE2 |=> nv_data_write_enable_r; endproperty
   a_kdat: assert property (p_kdat) else $error("data key lost");
   property p_kclr; key && sfr_wdata != 8'hE2 && sfr_wdata != 8'h47
      |=> !nv_data_write_enable_r && !flash_write_enable_r; endproperty
   a_kclr: assert property (p_kclr) else $error("enables kept");
   property p_wait; xwr && win && !xaddr[0] && nv_data_write_enable_r && !cpu_wait_r
      |=> cpu_wait_r; endproperty
   a_wait: assert property (p_wait) else $error("no stall");
   property p_odd; xwr && xaddr[0] && !cpu_wait_r |=> !cpu_wait_r; endproperty
   a_odd: assert property (p_odd) else $error("odd write stalled");
   property p_dis; xwr && !nv_data_write_enable_r && !cpu_wait_r |=> !cpu_wait_r; endproperty
   a_dis: assert property (p_dis) else $error("locked write stalled");
   property p_rd; xrd && win && !cpu_wait_r |-> ##13 xrdata_valid_r; endproperty
   a_rd: assert property (p_rd) else $error("read late");
   property p_to; $rose(write_timeout_flag_r) |-> $past(cpu_wait_r) || $past(flash_busy);
   endproperty
   a_to: assert property (p_to) else $error("stray time-out");
   property p_abort; flash_abort_r |-> write_timeout_flag_r; endproperty
   a_abort: assert property (p_abort) else $error("abort without flag");
   property p_toclr; !flash_write_enable_r && !nv_data_write_enable_r && !cpu_wait_r
      && !flash_busy |=> !write_timeout_flag_r; endproperty
   a_toclr: assert property (p_toclr) else $error("flag not cleared");
   c_rd: cover property (xrdata_valid_r);
   c_to: cover property ($rose(write_timeout_flag_r));
   c_wr: cover property ($fell(cpu_wait_r));
   c_ab: cover property (flash_abort_r);
endmodule // eda_ctrl_sva
bind eda_ctrl eda_ctrl_sva u_sva (.clk, .rst, .xaddr, .xwr, .xrd, .sfr_addr, .sfr_wdata,
   .sfr_wr, .flash_busy, .flash_abort_r, .xrdata_valid_r, .cpu_wait_r, .flash_write_enable_r,
   .nv_data_write_enable_r, .write_timeout_flag_r);

/* verification/eda_cpu.sv */
`timescale 1ns/1ps
// CPU side: one bus access at a time
module eda_cpu (
   input wire clk, // Clock
   input wire [7:0] xrdata_r, // Read byte
   input wire xrdata_valid_r, // Valid
   input wire cpu_wait_r, // Stall
   input wire [7:0] sfr_rdata_r, // SFR data
   output reg [15:0] xaddr = 16'h0000, // Address
   output reg [7:0] xwdata = 8'h00, // Data
   output reg xwr = 1'b0, // Write
   output reg xrd = 1'b0, // Read
   output reg [7:0] sfr_addr = 8'h00, // SFR
   output reg [7:0] sfr_wdata = 8'h00, // SFR data
   output reg sfr_wr = 1'b0 // SFR write
);
   // Write, then count stalled cycles; data inverted as the strobe drops
   task wr(input [15:0] a, input [7:0] d, output integer k);
   begin
      @(posedge clk); xaddr <= a; xwdata <= d; xwr <= 1'b1;
      @(posedge clk); xwr <= 1'b0; xwdata <= ~d;
      k = 0;
      #1;
      // A stalled CPU issues nothing until the stall ends
      while (cpu_wait_r && k < 99) begin k = k + 1; @(posedge clk); #1; end
   end
   endtask
   // Read, returning byte and latency
   task rd(input [15:0] a, output [7:0] q, output integer k);
   begin
      @(posedge clk); xaddr <= a; xrd <= 1'b1;
      @(posedge clk); xrd <= 1'b0; xaddr <= ~a;
      k = 0;
      do begin @(posedge clk); #1; k = k + 1; end while (!xrdata_valid_r && k < 99);
      q = xrdata_r;
   end
   endtask
   task sw(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk); sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
      @(posedge clk); sfr_wr <= 1'b0; sfr_wdata <= ~d;
   end
   endtask
   task sr(input [7:0] a, output [7:0] q);
   begin
      @(posedge clk); sfr_addr <= a;
      @(posedge clk); #1; q = sfr_rdata_r;
   end
   endtask
endmodule // eda_cpu

/* verification/eeprom_data_access_ctrl_test.sv */
`timescale 1ns/1ps
module eeprom_data_access_ctrl_test;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg flash_busy = 1'b0;
   wire [15:0] xaddr;
   wire [7:0] xwdata, sfr_addr, sfr_wdata, xrdata_r, sfr_rdata_r;
   wire xwr, xrd, sfr_wr, xrdata_valid_r, cpu_wait_r, flash_abort_r;
   wire flash_write_enable_r, nv_data_write_enable_r, write_timeout_flag_r;
   integer err_count = 0, samples_checked = 0, cyc = 0, k;
   reg [7:0] q;
   initial forever #12.5 clk = ~clk;
   // Short write and first time-out keep the run brief
   eda_ctrl #(.WRITE_CYC(20), .TO1_CYC(10)) DUT (.clk, .rst, .xaddr, .xwdata, .xwr, .xrd,
      .sfr_addr, .sfr_wdata, .sfr_wr, .flash_busy, .nv_busy_done(1'b0), .xrdata_r,
      .xrdata_valid_r, .cpu_wait_r, .sfr_rdata_r, .flash_abort_r, .flash_write_enable_r,
      .nv_data_write_enable_r, .write_timeout_flag_r);
   eda_cpu cpu (.clk, .xrdata_r, .xrdata_valid_r, .cpu_wait_r, .sfr_rdata_r, .xaddr, .xwdata,
      .xwr, .xrd, .sfr_addr, .sfr_wdata, .sfr_wr);
   task chk(input [31:0] s, input [31:0] e);
   begin
      samples_checked = samples_checked + 1;
      if (s !== e)
      begin
         err_count = err_count + 1;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   end
   endtask
   task finish_test;
   begin
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count = err_count + 1;
         finish_test;
      end
   end
   task t_write;
   begin
      cpu.sr(8'hC9, q); chk(q[7:5], 3'b000);
      cpu.sr(8'hF7, q); chk(q[2:1], 2'b11);
      cpu.sw(8'hC9, 8'hE2); cpu.sr(8'hC9, q); chk(q[7:5], 3'b001);
      cpu.wr(16'hEEFE, 8'hA5, k); chk(k, 20);
      cpu.wr(16'hEE00, 8'h5A, k); chk(k, 20);
      cpu.rd(16'hEEFE, q, k); chk(q, 8'hA5);
      chk(k, 12);
      $display("Write test done");
   end
   endtask
   task t_ignore;
   begin
      cpu.wr(16'hEE01, 8'hFF, k); chk(k, 0);
      cpu.sw(8'hC9, 8'h47); cpu.sr(8'hC9, q); chk(q[7:5], 3'b100);
      cpu.wr(16'hEE00, 8'h3C, k); chk(k, 0);
      cpu.rd(16'hEE00, q, k); chk(q, 8'h5A);
      $display("Ignore test done");
   end
   endtask
   task t_timeout;
   begin
      cpu.sw(8'hC9, 8'hE2); cpu.sw(8'hF7, 8'h02);
      cpu.wr(16'hEE00, 8'hC3, k); chk(k < 20, 1);
      chk(k > 9, 1);
      cpu.sr(8'hC9, q); chk(q[6], 1);
      cpu.rd(16'hEE00, q, k); chk(q, 8'h5A);
      cpu.sw(8'hC9, 8'h00); cpu.sr(8'hC9, q); chk(q[7:5], 3'b000);
      $display("Time-out test done");
   end
   endtask
   // Stuck flash write meets the shared time-out, then a mid-run reset
   task t_flash;
   begin
      cpu.sw(8'hC9, 8'h47); cpu.sw(8'hF7, 8'h02);
      @(posedge clk); flash_busy <= 1'b1;
      k = 0;
      @(posedge clk); #1;
      while (!flash_abort_r && k < 99) begin k = k + 1; @(posedge clk); #1; end
      chk(k, 10);
      @(posedge clk); flash_busy <= 1'b0;
      #1; chk(flash_abort_r, 0);
      cpu.sr(8'hC9, q); chk(q[7:5], 3'b110);
      @(posedge clk); rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cpu.sr(8'hC9, q); chk(q[7:5], 3'b000);
      cpu.sr(8'hF7, q); chk(q[2:1], 2'b11);
      $display("Flash time-out test done");
   end
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_write;
      t_ignore;
      t_timeout;
      t_flash;
      finish_test;
   end
endmodule // eeprom_data_access_ctrl_test
